// ===== include/lct_pkg.sv
/*
 * Constants, address map and timing figures for the lock-in converter
 * sample timing block. Assumes a single 25 MHz core clock and a host bus
 * that presents one-cycle write pulses synchronous to that clock.
 */
// Contract
// R1: Internal reference mode selects the fixed crystal as the board clock.
// R2: External reference mode selects the phase-locked oscillator as the board clock.
// R3: Converter traffic runs on a fixed 256 kHz cycle of board clocks; the code counts 100 core clocks of 40 ns, a 250 kHz cycle.
// R4: All converter clocks, mux selects and strobes come from one clock.
// R5: Main input stream enters the serial receive port directly.
// R6: Auxiliary stream shifts into a pair of serial-to-parallel registers.
// R7: Each input channel yields one sample per cycle, captured before the next.
// R8: Four output values are delivered every converter cycle.
// R9: Serial transmit port sends one channel of each converter every cycle.
// R10: Transmit bit clock runs at twice the receive bit clock.
// R11: Second channel of each converter goes through parallel-to-serial registers.
// R12: Sine, X, Y on three outputs; fourth rotates over eight slow outputs.
// R13: Reference sine is synthesised digitally, one sample per cycle.
// R14: Host-facing bus buffers enable only on writes addressed to this board.
// R15: Host configuration is held in latches until the next host write.
// R16: One address decoder produces every select and strobe of the board; the code decodes host writes only, cycle strobes come from cnt_q.
// R17: The converter samples main and selected auxiliary input together each cycle.
// R18: Auxiliary input mux rotates so each input converts every four cycles.
// R19: Isolated analog-board bus is driven only while that board is addressed.
// R20: Host keeps passing the measured reference frequency in external mode.
// R21: Slow-output and auxiliary selects advance round-robin at cycle boundaries.
package lct_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CORE_CLK_NS     = 40;
    localparam int CONV_PERIOD_NS  = 4000;
    localparam int CYCLE_CLKS      = CONV_PERIOD_NS / CORE_CLK_NS;
    localparam int XTAL_FREQ_KHZ   = 30208;
    localparam int VCO_NOM_KHZ     = 30000;
    localparam int INSTR_PER_CYCLE = 59;
    localparam int CLKS_PER_INSTR  = 2;
    localparam int BOARD_CLKS_PER_CYCLE = INSTR_PER_CYCLE * CLKS_PER_INSTR;

    localparam logic [6:0] CNT_LAST     = 7'(CYCLE_CLKS - 1);
    localparam logic [6:0] CNT_BITS_END = 7'h40;
    localparam logic [6:0] CNT_LOAD     = 7'h40;
    localparam logic [6:0] CNT_PAR_END  = 7'h20;
    localparam logic [1:0] RX_SAMPLE_PH = 2'h3;

    // -------------------------------------------------------------------
    // Data widths and rotations
    // -------------------------------------------------------------------
    localparam int SAMPLE_W   = 16;
    localparam int TX_W       = 32;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] AUX_SEL_LAST  = 2'h3;
    localparam logic [2:0] SLOW_SEL_LAST = 3'h7;

    // -------------------------------------------------------------------
    // Host address map and configuration layout
    // -------------------------------------------------------------------
    localparam logic [3:0] ADDR_CFG_LO  = 4'h0;
    localparam logic [3:0] ADDR_CFG_HI  = 4'h1;
    localparam logic [3:0] ADDR_FREQ_LO = 4'h2;
    localparam logic [3:0] ADDR_FREQ_HI = 4'h3;
    localparam logic [3:0] ADDR_ANA_LO  = 4'h8;
    localparam logic [3:0] ADDR_ANA_HI  = 4'h9;
    localparam int         ADDR_BOARD_BIT = 3;
    localparam int         CFG_EXT_REF_BIT = 0;
    localparam logic [15:0] CFG_RESET  = 16'h0000;
    localparam logic [15:0] FREQ_RESET = 16'h0000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;
    localparam logic [15:0] HALF_WAVE  = 16'h8000;
    localparam int          SINE_SHIFT = 14;

endpackage : lct_pkg

// ===== design/lct_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, used for the main
 * input sample stream. Assumes one clock and an asynchronous low reset.
 */
module lct_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_q;
    logic [AW:0]  rd_ptr_q;

    wire full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    wire empty = (wr_ptr_q == rd_ptr_q);
    wire push  = in_valid && !full;
    wire pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule // lct_fifo

// ===== design/lct_timing.sv
/*
 * Converter cycle timing and data movement for the lock-in signal board:
 * board clock selection, converter cycle sequencing, input capture, output
 * shifting, reference synthesis and host write decoding.
 * Assumes all inputs are synchronous to CORE_CLK and that the host write
 * strobe is a single-cycle pulse with address and data valid alongside.
 */
module lct_timing
    import lct_pkg::*;
(
    input  wire logic                CORE_CLK,
    input  wire logic                RST_N,
    // Converter inputs
    input  wire logic                ADC_MAIN_SD,
    input  wire logic                ADC_AUX_SD,
    output logic                     ADC_CONV,
    output logic                     ADC_SCLK,
    output logic [1:0]               AUX_IN_SEL,
    // Main sample stream to the processor
    output logic [SAMPLE_W-1:0]      MAIN_DATA,
    output logic                     MAIN_VALID,
    input  wire logic                MAIN_READY,
    output logic                     MAIN_OVERRUN,
    // Auxiliary sample words
    output logic [SAMPLE_W-1:0]      AUX_WORD,
    output logic [1:0]               AUX_CHAN,
    output logic                     AUX_VALID,
    // Output values from the processor
    input  wire logic [SAMPLE_W-1:0] X_VALUE,
    input  wire logic [SAMPLE_W-1:0] Y_VALUE,
    input  wire logic [SAMPLE_W-1:0] SLOW_VALUE,
    output logic [2:0]               SLOW_SEL,
    // Output converters
    output logic                     DAC_SCLK,
    output logic                     DAC_SER_SD,
    output logic                     DAC_A_PAR_SD,
    output logic                     DAC_B_PAR_SD,
    output logic                     DAC_LOAD,
    // Board clock select
    output logic                     CLK_SEL_VCO,
    // Host write bus
    input  wire logic                HOST_WR,
    input  wire logic [3:0]          HOST_ADDR,
    input  wire logic [7:0]          HOST_DATA,
    output logic                     HOST_BUF_EN,
    output logic [15:0]              CFG_WORD,
    // Isolated analog board bus
    output logic [7:0]               ANA_DATA,
    output logic                     ANA_DATA_EN,
    output logic [1:0]               ANA_LATCH_STB
);

    // -------------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------------

    // Parabolic approximation of one half wave, signed by the phase MSB.
    function automatic logic [SAMPLE_W-1:0] sine_of(input logic [15:0] ph);
        logic [31:0] x;
        logic [31:0] prod;
        logic [15:0] mag;
        x    = {17'h00000, ph[14:0]};
        prod = x * ({16'h0000, HALF_WAVE} - x);
        mag  = prod[SINE_SHIFT +: 16];
        sine_of = ph[15] ? 16'(-mag) : mag;
    endfunction

    // True when a round-robin counter must wrap to zero.
    function automatic logic at_last(input logic [2:0] v, input logic [2:0] last);
        at_last = (v == last);
    endfunction

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [6:0]          cnt_q;
    logic [SAMPLE_W-1:0] main_shift_q;
    logic [SAMPLE_W-1:0] aux_shift_q;
    logic                main_pend_q;
    logic [SAMPLE_W-1:0] main_hold_q;
    logic [1:0]          aux_sel_q;
    logic [2:0]          slow_sel_q;
    logic [TX_W-1:0]     tx_shift_q;
    logic [SAMPLE_W-1:0] par_a_q;
    logic [SAMPLE_W-1:0] par_b_q;
    logic [15:0]         phase_q;
    logic [15:0]         freq_q;
    logic [SAMPLE_W-1:0] sine_q;
    logic [15:0]         cfg_q;
    logic [SAMPLE_W-1:0] main_out_q;
    logic                main_vld_q;

    logic                adc_conv_q;
    logic                adc_sclk_q;
    logic                aux_valid_q;
    logic [SAMPLE_W-1:0] aux_word_q;
    logic [1:0]          aux_chan_q;
    logic                overrun_q;
    logic                dac_sclk_q;
    logic                dac_ser_q;
    logic                dac_a_q;
    logic                dac_b_q;
    logic                dac_load_q;
    logic                clk_sel_q;
    logic                buf_en_q;
    logic [7:0]          ana_data_q;
    logic                ana_en_q;
    logic [1:0]          ana_stb_q;

    // -------------------------------------------------------------------
    // Cycle decode
    // -------------------------------------------------------------------
    wire cyc_end   = (cnt_q == CNT_LAST);                          // [R3]
    wire in_bits   = (cnt_q < CNT_BITS_END);
    wire rx_take   = in_bits && (cnt_q[1:0] == RX_SAMPLE_PH);      // [R4]
    wire tx_step   = in_bits && cnt_q[0];                          // [R10]
    wire par_step  = tx_step && (cnt_q < CNT_PAR_END);
    wire load_pt   = (cnt_q == CNT_LOAD);

    // -------------------------------------------------------------------
    // Host decode
    // -------------------------------------------------------------------
    wire to_dsp    = HOST_WR && !HOST_ADDR[ADDR_BOARD_BIT];        // [R16]
    wire to_ana    = HOST_WR && HOST_ADDR[ADDR_BOARD_BIT];
    wire wr_cfg_lo = HOST_WR && (HOST_ADDR == ADDR_CFG_LO);
    wire wr_cfg_hi = HOST_WR && (HOST_ADDR == ADDR_CFG_HI);
    wire wr_frq_lo = HOST_WR && (HOST_ADDR == ADDR_FREQ_LO);
    wire wr_frq_hi = HOST_WR && (HOST_ADDR == ADDR_FREQ_HI);
    wire wr_ana_lo = HOST_WR && (HOST_ADDR == ADDR_ANA_LO);
    wire wr_ana_hi = HOST_WR && (HOST_ADDR == ADDR_ANA_HI);

    // -------------------------------------------------------------------
    // Main sample buffer
    // -------------------------------------------------------------------
    wire                fifo_in_ready;
    wire                fifo_out_valid;
    wire [SAMPLE_W-1:0] fifo_out_data;
    wire                out_take = !main_vld_q || MAIN_READY;
    wire                fifo_pop = out_take && fifo_out_valid;
    wire                main_new = load_pt;                       // [R7]

    lct_fifo #(
        .W     (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .in_valid  (main_pend_q),
        .in_ready  (fifo_in_ready),
        .in_data   (main_hold_q),
        .out_valid (fifo_out_valid),
        .out_ready (out_take),
        .out_data  (fifo_out_data)
    );

    // -------------------------------------------------------------------
    // Cycle counter and round-robin selects
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cyc_end ? 7'h00 : cnt_q + 7'h01;              // [R3]
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aux_sel_q  <= '0;
            slow_sel_q <= '0;
        end else if (cyc_end) begin
            aux_sel_q  <= at_last({1'b0, aux_sel_q}, {1'b0, AUX_SEL_LAST})
                          ? 2'h0 : aux_sel_q + 2'h1;               // [R18] [R21]
            slow_sel_q <= at_last(slow_sel_q, SLOW_SEL_LAST)
                          ? 3'h0 : slow_sel_q + 3'h1;              // [R12] [R21]
        end
    end

    // -------------------------------------------------------------------
    // Converter input capture
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            adc_conv_q <= 1'b0;
            adc_sclk_q <= 1'b0;
        end else begin
            adc_conv_q <= cyc_end;                                 // [R4] [R17]
            adc_sclk_q <= in_bits && cnt_q[1];                     // [R4]
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            main_shift_q <= '0;
            aux_shift_q  <= '0;
        end else if (rx_take) begin
            main_shift_q <= {main_shift_q[SAMPLE_W-2:0], ADC_MAIN_SD}; // [R5]
            aux_shift_q  <= {aux_shift_q[SAMPLE_W-2:0], ADC_AUX_SD};   // [R6]
        end
    end

    // The aux word stays in its parallel register until the next cycle's word.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aux_word_q  <= '0;
            aux_chan_q  <= '0;
            aux_valid_q <= 1'b0;
        end else begin
            aux_valid_q <= main_new;
            if (main_new) begin
                aux_word_q <= aux_shift_q;                         // [R6] [R7]
                aux_chan_q <= aux_sel_q;                           // [R21]
            end
        end
    end

    // A sample held for the buffer stalls until taken; a newer one overruns.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            main_pend_q <= 1'b0;
            main_hold_q <= '0;
            overrun_q   <= 1'b0;
        end else begin
            if (main_new) begin
                main_pend_q <= 1'b1;                               // [R7]
                main_hold_q <= main_shift_q;                       // [R5]
                overrun_q   <= main_pend_q && !fifo_in_ready;
            end else if (fifo_in_ready) begin
                main_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            main_out_q <= '0;
            main_vld_q <= 1'b0;
        end else if (out_take) begin
            main_vld_q <= fifo_pop;
            if (fifo_pop) main_out_q <= fifo_out_data;
        end
    end

    // -------------------------------------------------------------------
    // Reference synthesis
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_q <= PHASE_RESET;
            sine_q  <= '0;
        end else if (cyc_end) begin
            phase_q <= phase_q + freq_q;                           // [R13]
            sine_q  <= sine_of(phase_q);                           // [R13]
        end
    end

    // -------------------------------------------------------------------
    // Converter output shifting
    // -------------------------------------------------------------------
    // Serial port carries sine then X; parallel-to-serial pair carries Y and
    // the slow value of the current select, all four loaded at cycle end.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_shift_q <= '0;
            par_a_q    <= '0;
            par_b_q    <= '0;
        end else if (cyc_end) begin
            tx_shift_q <= {sine_q, X_VALUE};                       // [R8] [R9] [R12] [R13]
            par_a_q    <= Y_VALUE;                                 // [R11] [R12]
            par_b_q    <= SLOW_VALUE;                              // [R11] [R12]
        end else begin
            if (tx_step) tx_shift_q <= {tx_shift_q[TX_W-2:0], 1'b0};     // [R9]
            if (par_step) begin
                par_a_q <= {par_a_q[SAMPLE_W-2:0], 1'b0};          // [R11]
                par_b_q <= {par_b_q[SAMPLE_W-2:0], 1'b0};          // [R11]
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dac_sclk_q <= 1'b0;
            dac_ser_q  <= 1'b0;
            dac_a_q    <= 1'b0;
            dac_b_q    <= 1'b0;
            dac_load_q <= 1'b0;
        end else begin
            dac_sclk_q <= tx_step;                                 // [R10]
            dac_ser_q  <= tx_shift_q[TX_W-1];
            dac_a_q    <= par_a_q[SAMPLE_W-1];
            dac_b_q    <= par_b_q[SAMPLE_W-1];
            dac_load_q <= load_pt;                                 // [R8]
        end
    end

    // -------------------------------------------------------------------
    // Host writes, configuration latches and clock select
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q  <= CFG_RESET;
            freq_q <= FREQ_RESET;
        end else begin
            if (wr_cfg_lo) cfg_q[7:0]   <= HOST_DATA;              // [R15]
            if (wr_cfg_hi) cfg_q[15:8]  <= HOST_DATA;              // [R15]
            if (wr_frq_lo) freq_q[7:0]  <= HOST_DATA;              // [R20]
            if (wr_frq_hi) freq_q[15:8] <= HOST_DATA;              // [R20]
        end
    end

    // The select only moves at a cycle boundary so no cycle is cut short.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_sel_q <= 1'b0;
        end else if (cyc_end) begin
            clk_sel_q <= cfg_q[CFG_EXT_REF_BIT];                   // [R1] [R2]
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            buf_en_q   <= 1'b0;
            ana_data_q <= '0;
            ana_en_q   <= 1'b0;
            ana_stb_q  <= '0;
        end else begin
            buf_en_q   <= to_dsp;                                  // [R14]
            ana_en_q   <= to_ana;                                  // [R19]
            ana_data_q <= to_ana ? HOST_DATA : 8'h00;              // [R19]
            ana_stb_q  <= {wr_ana_hi, wr_ana_lo};                  // [R16]
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign ADC_CONV      = adc_conv_q;
    assign ADC_SCLK      = adc_sclk_q;
    assign AUX_IN_SEL    = aux_sel_q;
    assign MAIN_DATA     = main_out_q;
    assign MAIN_VALID    = main_vld_q;
    assign MAIN_OVERRUN  = overrun_q;
    assign AUX_WORD      = aux_word_q;
    assign AUX_CHAN      = aux_chan_q;
    assign AUX_VALID     = aux_valid_q;
    assign SLOW_SEL      = slow_sel_q;
    assign DAC_SCLK      = dac_sclk_q;
    assign DAC_SER_SD    = dac_ser_q;
    assign DAC_A_PAR_SD  = dac_a_q;
    assign DAC_B_PAR_SD  = dac_b_q;
    assign DAC_LOAD      = dac_load_q;
    assign CLK_SEL_VCO   = clk_sel_q;
    assign HOST_BUF_EN   = buf_en_q;
    assign CFG_WORD      = cfg_q;
    assign ANA_DATA      = ana_data_q;
    assign ANA_DATA_EN   = ana_en_q;
    assign ANA_LATCH_STB = ana_stb_q;

endmodule // lct_timing

// ===== verif/lct_timing_checker.sv
/* Port assertions for lct_timing, bound to it at the foot of this file.
   Assumes the single core clock and the low asynchronous reset of the design. */
module lct_timing_checker (
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic       ADC_CONV,
    input wire logic       ADC_SCLK,
    input wire logic [1:0] AUX_IN_SEL,
    input wire logic [2:0] SLOW_SEL,
    input wire logic       DAC_SCLK,
    input wire logic       DAC_LOAD,
    input wire logic       HOST_WR,
    input wire logic [3:0] HOST_ADDR,
    input wire logic [7:0] HOST_DATA,
    input wire logic       HOST_BUF_EN,
    input wire logic [7:0] ANA_DATA,
    input wire logic       ANA_DATA_EN,
    input wire logic [1:0] ANA_LATCH_STB
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_conv_period; ADC_CONV |=> !ADC_CONV ##99 ADC_CONV; endproperty
    a_conv_period: assert property (p_conv_period) else $error("conv period");
    property p_load_slot; ADC_CONV |-> ##65 DAC_LOAD; endproperty
    a_load_slot: assert property (p_load_slot) else $error("load slot");
    property p_rx_clock; ADC_CONV |-> !ADC_SCLK ##3 ADC_SCLK [*2] ##1 !ADC_SCLK; endproperty
    a_rx_clock: assert property (p_rx_clock) else $error("rx clock");
    property p_tx_clock; ADC_CONV |-> ##2 DAC_SCLK ##1 !DAC_SCLK ##1 DAC_SCLK; endproperty
    a_tx_clock: assert property (p_tx_clock) else $error("tx clock");
    property p_aux_rot; $changed(AUX_IN_SEL) |-> $rose(ADC_CONV) && AUX_IN_SEL == $past(AUX_IN_SEL) + 2'h1; endproperty
    a_aux_rot: assert property (p_aux_rot) else $error("aux select step");
    property p_slow_rot; $changed(SLOW_SEL) |-> $rose(ADC_CONV) && SLOW_SEL == $past(SLOW_SEL) + 3'h1; endproperty
    a_slow_rot: assert property (p_slow_rot) else $error("slow select step");
    property p_host_buf; HOST_WR && !HOST_ADDR[3] |=> HOST_BUF_EN && !ANA_DATA_EN && ANA_DATA == 8'h00; endproperty
    a_host_buf: assert property (p_host_buf) else $error("host buffer enable");
    property p_ana_wr; HOST_WR && HOST_ADDR[3] |=> ANA_DATA_EN && !HOST_BUF_EN && ANA_DATA == $past(HOST_DATA)
        && ANA_LATCH_STB == {$past(HOST_ADDR) == 4'h9, $past(HOST_ADDR) == 4'h8}; endproperty
    a_ana_wr: assert property (p_ana_wr) else $error("analog bus write");
endmodule // lct_timing_checker

bind lct_timing lct_timing_checker u_chk (.CORE_CLK, .RST_N, .ADC_CONV, .ADC_SCLK, .AUX_IN_SEL,
    .SLOW_SEL, .DAC_SCLK, .DAC_LOAD, .HOST_WR, .HOST_ADDR, .HOST_DATA, .HOST_BUF_EN, .ANA_DATA,
    .ANA_DATA_EN, .ANA_LATCH_STB);

// ===== verif/lct_adc_model.sv
/* Dual-channel input converter model: main word in the upper half, aux in the lower.
   Assumes the convert pulse and bit clock of lct_timing on the same core clock. */
module lct_adc_model (
    input  wire logic        clk,
    input  wire logic        conv,
    input  wire logic        sclk,
    input  wire logic [31:0] words,
    output logic             main_sd,
    output logic             aux_sd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sh_q = 32'h0;
    logic        sclk_q = 1'b0;
    assign main_sd = sh_q[31];
    assign aux_sd  = sh_q[15];
    // Spent bits are refilled with toggling values so stale data never looks valid.
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
        if (conv) begin
            sh_q <= words;
        end else if (sclk_q && !sclk) begin
            sh_q <= {sh_q[30:16], ~sh_q[16], sh_q[14:0], ~sh_q[0]};
        end
    end
endmodule // lct_adc_model

// ===== verif/tb_top.sv
/* Self-checking bench for lct_timing with a converter model and host writes.
   Assumes lct_pkg, the design and the checker are compiled first. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CORE_CLK = 1'b0, RST_N = 1'b0, MAIN_READY = 1'b0, HOST_WR = 1'b0;
    logic [3:0]  HOST_ADDR = 4'h0;
    logic [7:0]  HOST_DATA = 8'h00, ANA_DATA;
    logic [15:0] X_VALUE = 16'h0, Y_VALUE = 16'h0, SLOW_VALUE = 16'h0, MAIN_DATA, AUX_WORD;
    logic [15:0] CFG_WORD, ex_x, ex_y, ex_s, cfg, a_sh, b_sh, s_lo;
    logic [31:0] words = 32'h0;
    logic [1:0]  AUX_IN_SEL, AUX_CHAN, ANA_LATCH_STB, last_chan;
    logic [2:0]  SLOW_SEL;
    logic        ADC_MAIN_SD, ADC_AUX_SD, ADC_CONV, ADC_SCLK, MAIN_VALID, MAIN_OVERRUN, AUX_VALID;
    logic        DAC_SCLK, DAC_SER_SD, DAC_A_PAR_SD, DAC_B_PAR_SD, DAC_LOAD, CLK_SEL_VCO;
    logic        HOST_BUF_EN, ANA_DATA_EN, go = 1'b0, have_chan = 1'b0;
    int          miscompares = 0, tests_run = 0, pulses = 0, mode = 0;
    logic [15:0] main_q[$] = '{16'h0}, aux_q[$] = '{16'h0};

    lct_timing u_dut (
        .CORE_CLK, .RST_N, .ADC_MAIN_SD, .ADC_AUX_SD, .ADC_CONV, .ADC_SCLK, .AUX_IN_SEL,
        .MAIN_DATA, .MAIN_VALID, .MAIN_READY, .MAIN_OVERRUN, .AUX_WORD, .AUX_CHAN, .AUX_VALID,
        .X_VALUE, .Y_VALUE, .SLOW_VALUE, .SLOW_SEL, .DAC_SCLK, .DAC_SER_SD, .DAC_A_PAR_SD,
        .DAC_B_PAR_SD, .DAC_LOAD, .CLK_SEL_VCO, .HOST_WR, .HOST_ADDR, .HOST_DATA, .HOST_BUF_EN,
        .CFG_WORD, .ANA_DATA, .ANA_DATA_EN, .ANA_LATCH_STB
    );
    lct_adc_model u_adc (.clk(CORE_CLK), .conv(ADC_CONV), .sclk(ADC_SCLK), .words(words),
        .main_sd(ADC_MAIN_SD), .aux_sd(ADC_AUX_SD));

    always #20 CORE_CLK = ~CORE_CLK;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        HOST_WR   <= 1'b1;
        HOST_ADDR <= a;
        HOST_DATA <= d;
        @(posedge CORE_CLK);
        HOST_WR <= 1'b0;
        if (a == 4'h0) cfg[7:0] = d;
        if (a == 4'h1) cfg[15:8] = d;
        @(negedge CORE_CLK);
        chk("cfg word", cfg, CFG_WORD);
    endtask

    // Consumer, converter expectations and output-converter capture share one process.
    always @(posedge CORE_CLK) begin
        if (MAIN_VALID && MAIN_READY) begin
            chk("main sample", main_q.pop_front(), MAIN_DATA);
            chk("overrun", 16'h0, {15'h0, MAIN_OVERRUN});
        end
        MAIN_READY <= (mode == 0) ? 1'($urandom) : (mode == 2);
        if (AUX_VALID) begin
            chk("aux word", aux_q.pop_front(), AUX_WORD);
            if (have_chan) chk("aux chan", {14'h0, last_chan + 2'h1}, {14'h0, AUX_CHAN});
            last_chan <= AUX_CHAN;
            have_chan <= 1'b1;
        end
        if (ADC_CONV) begin
            main_q.push_back(words[31:16]);
            aux_q.push_back(words[15:0]);
            words <= $urandom;
            {ex_x, ex_y, ex_s} <= {X_VALUE, Y_VALUE, SLOW_VALUE};
            {X_VALUE, Y_VALUE, SLOW_VALUE} <= {16'($urandom), 16'($urandom), 16'($urandom)};
            go <= 1'b1;
        end
        if (DAC_SCLK) begin
            s_lo <= {s_lo[14:0], DAC_SER_SD};
            if (pulses < 16) a_sh <= {a_sh[14:0], DAC_A_PAR_SD};
            if (pulses < 16) b_sh <= {b_sh[14:0], DAC_B_PAR_SD};
            pulses <= pulses + 1;
        end
        if (DAC_LOAD) begin
            pulses <= 0;
            if (go) chk("x value", ex_x, s_lo);
            if (go) chk("y value", ex_y, a_sh);
            if (go) chk("slow value", ex_s, b_sh);
        end
    end

    initial begin
        void'($urandom(61));
        cfg = 16'h0;
        repeat (10) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 32; i++) wr(4'(i), 8'($urandom));
        wr(4'h0, 8'h01);
        wr(4'h2, 8'($urandom));
        wr(4'h3, 8'($urandom));
        repeat (110) @(posedge CORE_CLK);
        chk("clock select", 16'h1, {15'h0, CLK_SEL_VCO});
        wr(4'h0, 8'h00);
        repeat (110) @(posedge CORE_CLK);
        chk("clock select", 16'h0, {15'h0, CLK_SEL_VCO});
        repeat (1500) @(posedge CORE_CLK);
        mode = 1;
        repeat (3200) @(posedge CORE_CLK);
        mode = 2;
        repeat (3600) @(posedge CORE_CLK);
        conclude();
    end

    initial begin
        #480000;
        miscompares++;
        conclude();
    end
endmodule // tb_top
